// ### verilog/rbc_params.svh
// constants for the reset and ram back-up control block
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH

`define RBC_CLK_PERIOD_NS 8
`define RBC_SETTLE_NS 2000
`define RBC_SETTLE_CYC \
  ((`RBC_SETTLE_NS + `RBC_CLK_PERIOD_NS - 1) / `RBC_CLK_PERIOD_NS)

`define RBC_PC_START 0
`define RBC_STACK_BACKUP 3'h7
`define RBC_STACK_RESET 3'h7
`define RBC_FLAGS_RESET 9'h004
`define RBC_KEEP_RESET 40'h0000000000
`define RBC_LOSE_RESET 16'h0000
`define RBC_WDT_W 16
`define RBC_PC_W 13
`define RBC_WAKE_W 12

`define RBC_FLAG_IE 8
`define RBC_FLAG_EXT 7
`define RBC_FLAG_T1 6
`define RBC_FLAG_T2 5
`define RBC_FLAG_WD1 4
`define RBC_FLAG_WD2 3
`define RBC_FLAG_WEN 2
`define RBC_FLAG_ADC 1
`define RBC_FLAG_CARRY 0

`endif

// ### verilog/rbc_pkg.sv
// types of the reset and ram back-up control block
package rbc_pkg;

  typedef enum logic [1:0] {
    RBC_ST_RUN = 2'h0,
    RBC_ST_BACKUP = 2'h1,
    RBC_ST_SETTLE = 2'h3,
    RBC_ST_RESTART = 2'h2
  } rbc_state_t;

  typedef enum logic [2:0] {
    RBC_OP_OTHER = 3'h0,
    RBC_OP_ARM = 3'h1,
    RBC_OP_ENTER = 3'h2,
    RBC_OP_SKIP_PD = 3'h3,
    RBC_OP_WDT_RESTART = 3'h4
  } rbc_instr_t;

  typedef struct packed {
    logic interrupt_enable_flag;
    logic external_request_flag;
    logic timer_one_request_flag;
    logic timer_two_request_flag;
    logic watchdog_flag_first;
    logic watchdog_flag_second;
    logic watchdog_enable_flag;
    logic conversion_done_flag;
    logic carry_flag;
  } rbc_flags_t;

  typedef struct packed {
    logic [3:0] timer_control_two;
    logic [3:0] timer_control_six;
    logic [3:0] external_interrupt_control;
    logic [3:0] converter_control_reg;
    logic [3:0] pullup_control_port_zero;
    logic [3:0] pullup_control_port_one;
    logic [3:0] pullup_control_port_two;
    logic [3:0] wakeup_control_port_zero;
    logic [3:0] wakeup_control_port_one;
    logic [3:0] wakeup_control_port_two;
  } rbc_keep_cfg_t;

  typedef struct packed {
    logic [3:0] timer_control_one;
    logic [3:0] clock_control_reg;
    logic [3:0] interrupt_control_first;
    logic [3:0] interrupt_control_second;
  } rbc_lose_cfg_t;

endpackage : rbc_pkg

// ### verilog/rbc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rbc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // only the second stage is ever looked at
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;
endmodule : rbc_sync

// ### verilog/rbc_settle.sv
// oscillator settling down-counter, one pulse when done
`timescale 1ns/10ps
module rbc_settle #(
  parameter int COUNT = 250
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (start)
    begin
      cnt_ff <= CW'(COUNT - 1);
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end
    else if (busy_ff)
    begin
      done_ff <= (cnt_ff == '0);
      busy_ff <= (cnt_ff != '0);
      cnt_ff <= (cnt_ff == '0) ? cnt_ff : cnt_ff - 1'b1;
    end
    else
    begin
      done_ff <= 1'b0;
    end
  end

  assign done = done_ff;
endmodule : rbc_settle

// ### verilog/rbc_ctrl.sv
// reset and ram back-up control of the 4-bit core
// Behaviour
// RULE1 - reset loads program counter with zero
// RULE2 - reset clears timer and watchdog flags
// RULE3 - reset clears conversion flag and carry
// RULE4 - reset sets watchdog enable flag
// RULE5 - software initialises everything left undefined
// RULE6 - back-up only on arm then enter
// RULE7 - lone enter instruction acts as nop
// RULE8 - back-up stops oscillator, keeps ram
// RULE9 - wakeup restarts at zero, power-down set
// RULE10 - pin or watchdog reset clears power-down
// RULE11 - skip instruction tests power-down flag
// RULE12 - back-up keeps ports, oscillator, listed registers; the code stops the oscillator (osc_stop high in back-up)
// RULE13 - back-up initialises the listed volatile state
// RULE14 - back-up sets stack pointer to seven
// RULE15 - timer two state undefined after back-up
// RULE16 - back-up clears watchdog flag and counter
// RULE17 - only wakeup or reset leaves back-up
// RULE18 - reset pin held low one machine cycle
// RULE19 - wakeup waits for oscillator to settle
// RULE20 - any other instruction cancels the arming
`timescale 1ns/10ps
`include "rbc_params.svh"
module rbc_ctrl
  import rbc_pkg::*;
#(
  parameter int PC_W = `RBC_PC_W,
  parameter int WDT_W = `RBC_WDT_W,
  parameter int WAKE_W = `RBC_WAKE_W,
  parameter int SETTLE_CYC = `RBC_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic [WAKE_W-1:0] wake_pin_n,
  input wire logic instr_valid,
  input wire rbc_instr_t instr_op,
  input wire logic flag_wr_en,
  input wire rbc_flags_t flag_wr_data,
  input wire logic keep_wr_en,
  input wire rbc_keep_cfg_t keep_wr_data,
  input wire logic lose_wr_en,
  input wire rbc_lose_cfg_t lose_wr_data,
  output logic cpu_run,
  output logic osc_stop,
  output logic port_hold,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output logic volatile_init,
  output logic [2:0] stack_pointer,
  output logic skip_next,
  output logic power_down_flag,
  output rbc_flags_t flags,
  output rbc_keep_cfg_t keep_cfg,
  output rbc_lose_cfg_t lose_cfg,
  output logic [WDT_W-1:0] watchdog_counter,
  output logic armed
);

  rbc_state_t state_ff;
  rbc_state_t nxt_state;
  logic [WAKE_W:0] pins_sync;
  logic reset_pin_sync_n;
  logic [WAKE_W-1:0] wake_sync_n;
  logic settle_done;
  logic cpu_run_ff;
  logic osc_stop_ff;
  logic port_hold_ff;
  logic pc_load_ff;
  logic [PC_W-1:0] pc_value_ff;
  logic volatile_init_ff;
  logic [2:0] stack_pointer_ff;
  logic skip_next_ff;
  logic power_down_flag_ff;
  rbc_flags_t flags_ff;
  rbc_flags_t nxt_flags;
  rbc_keep_cfg_t keep_cfg_ff;
  rbc_lose_cfg_t lose_cfg_ff;
  logic [WDT_W-1:0] watchdog_counter_ff;
  logic armed_ff;
  logic wdt_reset_ff;
  logic cold_req;
  logic exec;
  logic enter_backup;
  logic wake_hit;
  logic wdt_wrap;

  // one executed instruction, seen only while the core runs
  function automatic logic is_op(input logic v, input rbc_instr_t op,
                                 input rbc_instr_t want);
    is_op = v && (op == want);
  endfunction : is_op

  rbc_sync #(
    .WIDTH(WAKE_W + 1),
    .RST_VAL({(WAKE_W + 1){1'b1}})
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin_in({reset_pin_n, wake_pin_n}),
    .pin_sync(pins_sync)
  );

  assign reset_pin_sync_n = pins_sync[WAKE_W];
  assign wake_sync_n = pins_sync[WAKE_W-1:0];

  rbc_settle #(
    .COUNT(SETTLE_CYC)
  ) u_settle (
    .core_clk(core_clk),
    .rst(rst),
    .start(state_ff == RBC_ST_BACKUP && wake_hit),
    .done(settle_done)
  );

  // a low pin is caught as soon as it has crossed the synchroniser
  assign cold_req = !reset_pin_sync_n || wdt_reset_ff; // RULE18
  assign exec = instr_valid && (state_ff == RBC_ST_RUN) && !cold_req;
  assign enter_backup = is_op(exec, instr_op, RBC_OP_ENTER) &&
                        armed_ff; // RULE6
  // key-on lines low while their wakeup control bit is set
  assign wake_hit = |(~wake_sync_n & {keep_cfg_ff.wakeup_control_port_two,
                                      keep_cfg_ff.wakeup_control_port_one,
                                      keep_cfg_ff.wakeup_control_port_zero});
  assign wdt_wrap = (state_ff == RBC_ST_RUN) &&
                    flags_ff.watchdog_enable_flag &&
                    (watchdog_counter_ff == {WDT_W{1'b1}});

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      RBC_ST_RUN:
      begin
        if (enter_backup)
          nxt_state = RBC_ST_BACKUP;
      end
      RBC_ST_BACKUP:
      begin
        // timers are frozen here, so no internal event can wake us
        if (wake_hit)
          nxt_state = RBC_ST_SETTLE; // RULE17
      end
      RBC_ST_SETTLE:
      begin
        if (settle_done)
          nxt_state = RBC_ST_RESTART; // RULE19
      end
      RBC_ST_RESTART:
      begin
        if (!cold_req)
          nxt_state = RBC_ST_RUN;
      end
      default:
        nxt_state = RBC_ST_RESTART;
    endcase
    if (cold_req)
      nxt_state = RBC_ST_RESTART;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      state_ff <= RBC_ST_RESTART;
    else
      state_ff <= nxt_state;
  end

  // status outputs follow the state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cpu_run_ff <= 1'b0;
      osc_stop_ff <= 1'b0;
      port_hold_ff <= 1'b0;
    end
    else
    begin
      cpu_run_ff <= (nxt_state == RBC_ST_RUN);
      osc_stop_ff <= (nxt_state == RBC_ST_BACKUP); // RULE8
      // pins keep their levels while the core is asleep
      port_hold_ff <= (nxt_state == RBC_ST_BACKUP) ||
                      (nxt_state == RBC_ST_SETTLE); // RULE12
    end
  end

  // restart from page zero, address zero on every release
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pc_load_ff <= 1'b0;
      pc_value_ff <= PC_W'(`RBC_PC_START); // RULE1
    end
    else
    begin
      pc_load_ff <= (state_ff == RBC_ST_RESTART) &&
                    (nxt_state == RBC_ST_RUN); // RULE1 RULE9 RULE10
      pc_value_ff <= PC_W'(`RBC_PC_START);
    end
  end

  // accumulators, timer one and converter are told to reset
  always_ff @(posedge core_clk)
  begin
    if (rst)
      volatile_init_ff <= 1'b1;
    else
      volatile_init_ff <= enter_backup || cold_req; // RULE13
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      stack_pointer_ff <= `RBC_STACK_RESET;
    else if (enter_backup)
      stack_pointer_ff <= `RBC_STACK_BACKUP; // RULE14
  end

  // arm survives exactly one instruction
  always_ff @(posedge core_clk)
  begin
    if (rst)
      armed_ff <= 1'b0;
    else if (cold_req)
      armed_ff <= 1'b0;
    else if (exec)
      armed_ff <= (instr_op == RBC_OP_ARM); // RULE20 RULE7
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      skip_next_ff <= 1'b0;
    else
      skip_next_ff <= is_op(exec, instr_op, RBC_OP_SKIP_PD) &&
                      power_down_flag_ff; // RULE11
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      power_down_flag_ff <= 1'b0;
    else if (cold_req)
      power_down_flag_ff <= 1'b0; // RULE10
    else if (state_ff == RBC_ST_SETTLE && settle_done)
      power_down_flag_ff <= 1'b1; // RULE9
  end

  // watchdog: first wrap raises the first flag, the next one resets
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      watchdog_counter_ff <= '0;
      wdt_reset_ff <= 1'b0;
    end
    else
    begin
      wdt_reset_ff <= wdt_wrap && flags_ff.watchdog_flag_first;
      if (cold_req || enter_backup)
        watchdog_counter_ff <= '0; // RULE16
      else if (is_op(exec, instr_op, RBC_OP_WDT_RESTART))
        watchdog_counter_ff <= '0;
      else if (state_ff == RBC_ST_RUN && flags_ff.watchdog_enable_flag)
        watchdog_counter_ff <= watchdog_counter_ff + 1'b1;
    end
  end

  always_comb
  begin
    nxt_flags = flags_ff;
    if (flag_wr_en && exec)
      nxt_flags = flag_wr_data;
    if (is_op(exec, instr_op, RBC_OP_WDT_RESTART))
      nxt_flags.watchdog_flag_first = 1'b0;
    // hardware set beats a software clear in the same cycle
    if (wdt_wrap)
    begin
      nxt_flags.watchdog_flag_first = 1'b1;
      if (flags_ff.watchdog_flag_first)
        nxt_flags.watchdog_flag_second = 1'b1;
    end
    if (enter_backup)
    begin
      nxt_flags.carry_flag = 1'b0; // RULE13
      nxt_flags.timer_one_request_flag = 1'b0;
      nxt_flags.external_request_flag = 1'b0;
      nxt_flags.conversion_done_flag = 1'b0;
      nxt_flags.interrupt_enable_flag = 1'b0;
      nxt_flags.watchdog_enable_flag = 1'b1;
      nxt_flags.watchdog_flag_first = 1'b0; // RULE16
      // timer two and its flag simply stay where they were
      nxt_flags.timer_two_request_flag =
        flags_ff.timer_two_request_flag; // RULE15
    end
    if (cold_req)
    begin
      nxt_flags = `RBC_FLAGS_RESET; // RULE2 RULE3 RULE4
      // second watchdog flag is cleared by the reset, watchdog reset included
      nxt_flags.watchdog_flag_second = 1'b0; // RULE2
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      flags_ff <= `RBC_FLAGS_RESET; // RULE2 RULE3 RULE4
    else
      flags_ff <= nxt_flags;
  end

  // retained set: untouched by back-up, only reset or software
  always_ff @(posedge core_clk)
  begin
    if (rst)
      keep_cfg_ff <= `RBC_KEEP_RESET;
    else if (keep_wr_en && exec)
      keep_cfg_ff <= keep_wr_data; // RULE12
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      lose_cfg_ff <= `RBC_LOSE_RESET;
    else if (enter_backup)
      lose_cfg_ff <= `RBC_LOSE_RESET; // RULE13
    else if (lose_wr_en && exec)
      lose_cfg_ff <= lose_wr_data;
  end

  assign cpu_run = cpu_run_ff;
  assign osc_stop = osc_stop_ff;
  assign port_hold = port_hold_ff;
  assign pc_load = pc_load_ff;
  assign pc_value = pc_value_ff;
  assign volatile_init = volatile_init_ff;
  assign stack_pointer = stack_pointer_ff;
  assign skip_next = skip_next_ff;
  assign power_down_flag = power_down_flag_ff;
  assign flags = flags_ff;
  assign keep_cfg = keep_cfg_ff;
  assign lose_cfg = lose_cfg_ff;
  assign watchdog_counter = watchdog_counter_ff;
  assign armed = armed_ff;

endmodule : rbc_ctrl

// ### sim/rbc_ctrl_props.sv
// port assertions of the reset and back-up control block
`timescale 1ns/10ps
module rbc_ctrl_props
  import rbc_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int WDT_W = 16,
  parameter int WAKE_W = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic [WAKE_W-1:0] wake_pin_n,
  input wire logic instr_valid,
  input wire rbc_instr_t instr_op,
  input wire logic keep_wr_en,
  input wire logic cpu_run,
  input wire logic osc_stop,
  input wire logic port_hold,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire logic volatile_init,
  input wire logic [2:0] stack_pointer,
  input wire logic skip_next,
  input wire logic power_down_flag,
  input wire rbc_flags_t flags,
  input wire rbc_keep_cfg_t keep_cfg,
  input wire logic [WDT_W-1:0] watchdog_counter,
  input wire logic armed
);
  logic [2:0] pin_hist_ff;
  logic calm;
  always_ff @(posedge core_clk)
  begin
    pin_hist_ff <= {pin_hist_ff[1:0], reset_pin_n};
  end
  // a pending pin or watchdog reset may pre-empt any instruction
  assign calm = &pin_hist_ff & reset_pin_n & ~flags.watchdog_flag_second;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence take(rbc_instr_t op);
    cpu_run && instr_valid && instr_op == op && calm;
  endsequence
  sequence arm_enter;
    take(RBC_OP_ARM) ##1 take(RBC_OP_ENTER);
  endsequence
  AST_LONE: assert property (
    take(RBC_OP_ENTER) ##0 !armed |=> cpu_run)
    else $error("lone enter left run state");
  AST_ENTER: assert property (
    arm_enter |=> osc_stop && port_hold && !cpu_run && volatile_init &&
    stack_pointer == 3'h7)
    else $error("arm then enter did not reach back-up");
  AST_INIT: assert property (
    arm_enter |=> (flags & 9'h1D7) == 9'h004 && watchdog_counter == '0)
    else $error("back-up entry init wrong");
  AST_KEEP: assert property (
    arm_enter ##0 !keep_wr_en |=> $stable(keep_cfg))
    else $error("retained config changed on entry");
  AST_STAY: assert property (
    (reset_pin_n && &wake_pin_n)[*3] ##0 osc_stop |=>
    osc_stop && $stable(watchdog_counter))
    else $error("back-up left without wakeup or reset");
  AST_WAKE: assert property (
    $fell(osc_stop) && calm |-> (port_hold && !cpu_run)[*3] ##[1:8]
    (pc_load && cpu_run && power_down_flag))
    else $error("warm restart sequence wrong");
  AST_COLD: assert property (
    !reset_pin_n[*4] |-> !cpu_run && !armed && !power_down_flag &&
    flags == 9'h004)
    else $error("pin reset state wrong");
  AST_PC: assert property (
    $rose(cpu_run) |-> pc_load && pc_value == '0)
    else $error("run began without load of address zero");
  AST_SKIP: assert property (take(RBC_OP_SKIP_PD) |=>
    skip_next == $past(power_down_flag))
    else $error("skip did not follow power-down flag");
  AST_DISARM: assert property (take(RBC_OP_OTHER) |=> !armed)
    else $error("other instruction left arming set");
endmodule : rbc_ctrl_props

bind rbc_ctrl rbc_ctrl_props #(.PC_W(PC_W), .WDT_W(WDT_W), .WAKE_W(WAKE_W))
  u_props (.core_clk, .rst, .reset_pin_n, .wake_pin_n, .instr_valid,
  .instr_op, .keep_wr_en, .cpu_run, .osc_stop, .port_hold, .pc_load,
  .pc_value, .volatile_init, .stack_pointer, .skip_next, .power_down_flag,
  .flags, .keep_cfg, .watchdog_counter, .armed);

// ### sim/rbc_pin_model.sv
// pin side model: reset source and key-on wakeup lines
`timescale 1ns/10ps
module rbc_pin_model (
  input wire logic core_clk,
  input wire logic rst_go,
  input wire logic wake_go,
  input wire logic [3:0] pin_sel,
  input wire logic [7:0] pin_hold,
  output logic reset_pin_n,
  output logic [11:0] wake_pin_n
);
  logic [7:0] rst_cnt_ff = 8'h00;
  logic [7:0] wake_cnt_ff = 8'h00;
  logic [3:0] sel_ff = 4'h0;
  always_ff @(posedge core_clk)
  begin
    if (rst_go)
      rst_cnt_ff <= (pin_hold == 8'h00) ? 8'h01 : pin_hold;
    else if (rst_cnt_ff != 8'h00)
      rst_cnt_ff <= rst_cnt_ff - 8'h01;
  end
  always_ff @(posedge core_clk)
  begin
    if (wake_go)
      wake_cnt_ff <= pin_hold;
    else if (wake_cnt_ff != 8'h00)
      wake_cnt_ff <= wake_cnt_ff - 8'h01;
    if (wake_go)
      sel_ff <= pin_sel;
  end
  // released lines fall back to their pull-ups
  assign reset_pin_n = (rst_cnt_ff == 8'h00);
  assign wake_pin_n = (wake_cnt_ff == 8'h00) ? 12'hFFF :
                      ~(12'h001 << sel_ff);
endmodule : rbc_pin_model

// ### sim/tb.sv
// self-checking bench of the reset and back-up control block
`timescale 1ns/10ps
module tb;
  import rbc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n, cpu_run, osc_stop, port_hold, pc_load;
  logic volatile_init, skip_next, power_down_flag, armed;
  logic [11:0] wake_pin_n;
  logic instr_valid = 1'b0;
  rbc_instr_t instr_op = RBC_OP_OTHER;
  logic flag_wr_en = 1'b0, keep_wr_en = 1'b0, lose_wr_en = 1'b0;
  rbc_flags_t flag_wr_data = '0, flags, fw;
  rbc_keep_cfg_t keep_wr_data = '0, keep_cfg, kc;
  rbc_lose_cfg_t lose_wr_data = '0, lose_cfg, lc;
  logic [12:0] pc_value, e;
  logic [2:0] stack_pointer;
  logic [7:0] watchdog_counter, pin_hold = 8'h00;
  logic rst_go = 1'b0, wake_go = 1'b0;
  logic [3:0] pin_sel = 4'h0;
  logic [63:0] r;
  logic [31:0] seed = 32'h0000823D;
  logic [12:0] q[$];
  int failures = 0, compares = 0, cycles = 0;
  rbc_ctrl #(.WDT_W(8), .SETTLE_CYC(4)) u_dut (.core_clk, .rst, .reset_pin_n,
    .wake_pin_n, .instr_valid, .instr_op, .flag_wr_en, .flag_wr_data,
    .keep_wr_en, .keep_wr_data, .lose_wr_en, .lose_wr_data, .cpu_run,
    .osc_stop, .port_hold, .pc_load, .pc_value, .volatile_init,
    .stack_pointer, .skip_next, .power_down_flag, .flags, .keep_cfg,
    .lose_cfg, .watchdog_counter, .armed);
  rbc_pin_model u_pins (.core_clk, .rst_go, .wake_go, .pin_sel, .pin_hold,
    .reset_pin_n, .wake_pin_n);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(input string nm, input logic [39:0] s, e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic stop_test();
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic ins(input rbc_instr_t op, input logic [2:0] we);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    {flag_wr_en, keep_wr_en, lose_wr_en} <= we;
    flag_wr_data <= fw;
    keep_wr_data <= kc;
    lose_wr_data <= lc;
  endtask : ins
  task automatic idle();
    @(posedge core_clk);
    instr_valid <= 1'b0;
    {flag_wr_en, keep_wr_en, lose_wr_en} <= 3'h0;
    #1;
  endtask : idle
  task automatic pins(input logic rg, wg, input logic [3:0] s,
                      input logic [7:0] h);
    @(posedge core_clk);
    rst_go <= rg;
    wake_go <= wg;
    pin_sel <= s;
    pin_hold <= h;
    @(posedge core_clk);
    rst_go <= 1'b0;
    wake_go <= 1'b0;
  endtask : pins
  // bounded wait for the restart load pulse
  task automatic wait_pc();
    for (int n = 0; n < 2000; n++)
    begin
      @(posedge core_clk);
      #1;
      if (pc_load === 1'b1)
        break;
    end
    check("pc wait", 40'(pc_load), 40'h1);
  endtask : wait_pc
  // software sets every flag and register it relies on; clears both watchdog flags, sets watchdog enable
  task automatic new_cfg();
    r = {xs(), xs()};
    fw = r[8:0] & 9'h1E3 | 9'h004;
    lc = r[55:40];
  endtask : new_cfg
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      stop_test();
    end
  end
  // timer two flag is left undefined by back-up, so it is masked
  always @(negedge core_clk)
  begin
    if (!rst && pc_load === 1'b1)
    begin
      e = (q.size() > 0) ? q.pop_front() : 13'h1FFF;
      check("restart",
        40'({power_down_flag, flags & 9'h1DF, stack_pointer}), 40'(e));
      check("pc start", 40'(pc_value), 40'h0);
    end
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    q.push_back({1'b0, 9'h004, 3'h7});
    rst <= 1'b0;
    wait_pc();
    r = {xs(), xs()};
    kc = r[39:0];
    kc.wakeup_control_port_zero = 4'h1;
    new_cfg();
    ins(RBC_OP_OTHER, 3'h7);
    idle();
    check("keep", 40'(keep_cfg), 40'(kc));
    ins(RBC_OP_ENTER, 3'h0);
    idle();
    check("lone", 40'({cpu_run, osc_stop, lose_cfg}), 40'({2'h2, lc}));
    ins(RBC_OP_ARM, 3'h0);
    ins(RBC_OP_OTHER, 3'h0);
    ins(RBC_OP_ENTER, 3'h0);
    idle();
    check("cancel", 40'({armed, cpu_run, osc_stop}), 40'(3'h2));
    for (int i = 0; i < 2; i++)
    begin
      new_cfg();
      ins(RBC_OP_OTHER, 3'h5);
      ins(RBC_OP_WDT_RESTART, 3'h0);
      ins(RBC_OP_ARM, 3'h0);
      ins(RBC_OP_ENTER, 3'h0);
      idle();
      check("enter",
        40'({cpu_run, osc_stop, port_hold, volatile_init, stack_pointer,
        flags & 9'h1D7, lose_cfg, watchdog_counter}),
        40'({4'h7, 3'h7, 9'h004, 24'h0}));
      pins(1'b0, 1'b1, 4'h1, 8'h08);
      repeat (20) @(posedge core_clk);
      #1;
      check("stay", 40'({osc_stop, watchdog_counter}),
        40'(9'h100));
      check("held", 40'(keep_cfg), 40'(kc));
      q.push_back({1'b1, 9'h004, 3'h7});
      pins(1'b0, 1'b1, 4'h0, 8'(4 + r[2:0]));
      wait_pc();
      ins(RBC_OP_SKIP_PD, 3'h0);
      idle();
      check("warm skip", 40'(skip_next), 40'(1'b1));
      q.push_back({1'b0, 9'h004, 3'h7});
      if (i == 1)
        pins(1'b1, 1'b0, 4'h0, 8'h06);
      wait_pc();
      ins(RBC_OP_SKIP_PD, 3'h0);
      idle();
      check("cold skip", 40'(skip_next), 40'(1'b0));
    end
    check("queue", 40'(q.size()), 40'h0);
    stop_test();
  end
endmodule : tb
